// ===== core/oprom_pkg.sv
// Package: constants for the on-chip PROM access and programming port
`default_nettype none
package oprom_pkg;
  localparam int ROM_BYTES = 131072;
  localparam int ROM_AW = 17;
  localparam logic [31:0] ROM_BASE = 32'h0000_0000;
  localparam logic [31:0] ROM_TOP = 32'h0001_ffff;
  localparam logic [3:0] MODE_PROM = 4'hf;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] BUS_W8 = 2'h0;
  localparam logic [1:0] BUS_W16 = 2'h1;
  localparam logic [1:0] BUS_W32 = 2'h2;
  localparam logic [1:0] BUS_WBSC = 2'h3;
endpackage
`default_nettype wire

// ===== core/oprom_mode_if.sv
// Interface: decoded operating mode shared between modules
`default_nettype none
interface oprom_mode_if;
  logic romEnable;
  logic promMode;
  logic singleChip;
  logic [1:0] area0Width;
  modport dec (output romEnable, output promMode, output singleChip, output area0Width);
  modport use_m (input romEnable, input promMode, input singleChip, input area0Width);
endinterface
`default_nettype wire

// ===== core/oprom_mode_dec.sv
// Mode pin decoder: ROM enable, PROM mode and area 0 width
`default_nettype none
module oprom_mode_dec
  import oprom_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] modeSelect,
  input wire logic largePackage,
  oprom_mode_if.dec modeIf
);
  typedef struct packed {
    logic romEn;
    logic prom;
    logic single;
    logic [1:0] width;
  } oprom_dec_t;
  oprom_dec_t st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    // RULE9: all four pins high
    nxt_st.prom = (modeSelect == MODE_PROM);
    // RULE4: enabled in modes 2 and 3
    nxt_st.romEn = modeSelect[1];
    // RULE8: mode 3 single chip
    nxt_st.single = modeSelect[1] & modeSelect[0];
    unique case (modeSelect[1:0])
      // RULE5: mode 0 width
      2'h0: nxt_st.width = largePackage ? BUS_W16 : BUS_W8;
      // RULE6: mode 1 width
      2'h1: nxt_st.width = largePackage ? BUS_W32 : BUS_W16;
      // RULE7: width from bus controller
      default: nxt_st.width = BUS_WBSC;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign modeIf.romEnable = st_ff.romEn;
  assign modeIf.promMode = st_ff.prom;
  assign modeIf.singleChip = st_ff.single;
  assign modeIf.area0Width = st_ff.width;
  a_rom_enable: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n && $past(rst_n) |-> modeIf.romEnable == $past(modeSelect[1])) // RULE4
    else $error("rom enable wrong");
  a_prom_entry: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) && $past(modeSelect) == MODE_PROM |-> modeIf.promMode) // RULE9
    else $error("prom mode missed");
  a_mode0_width: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) && $past(modeSelect[1:0]) == 2'h0 |-> !modeIf.romEnable && modeIf.area0Width != BUS_W32) // RULE5
    else $error("mode 0 wrong");
  a_mode1_width: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) && $past(modeSelect[1:0]) == 2'h1 |-> !modeIf.romEnable && modeIf.area0Width != BUS_W8) // RULE6
    else $error("mode 1 wrong");
  a_mode2_bsc: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) && $past(modeSelect[1:0]) == 2'h2 |-> modeIf.area0Width == BUS_WBSC && !modeIf.singleChip) // RULE7
    else $error("mode 2 wrong");
  a_mode3_single: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) && $past(modeSelect[1:0]) == 2'h3 |-> modeIf.singleChip && modeIf.romEnable) // RULE8
    else $error("mode 3 wrong");
endmodule
`default_nettype wire

// ===== core/oprom_top.sv
// Top: on-chip PROM array, internal read port and programming port
`default_nettype none
// What this block does
// RULE1: Serves byte, halfword and word reads from core, DMA and transfer controller.
// RULE2: Every array read completes in one cycle with no wait state.
// RULE3: When enabled the array decodes at area 0 bottom, 128 kbytes.
// RULE4: Array enabled in modes 2 and 3, disabled in modes 0 and 1.
// RULE5: Mode 0: array off, area 0 external, 8 or 16 bits wide.
// RULE6: Mode 1: array off, area 0 external, 16 or 32 bits wide.
// RULE7: Mode 2: array on, external width from bus controller.
// RULE8: Mode 3: array on, single-chip, no external space.
// RULE9: All four mode pins high enters programming mode, byte-wide port.
// RULE10: Programming mode offers byte write and verify read-back.
// RULE11: Strobe code selects write or verify; others leave data lines floating.
// RULE12: Programmer writes one byte per cycle, never page mode.
// RULE13: Programmer holds program pulse 0.19 to 0.21 ms, over-program to 5.25 ms; the model holds one 25 ns mclk cycle, no over-program.
// RULE14: Programmer aborts after failures at consecutive addresses.
// RULE15: Programmer pulses, verifies, retries up to a limit, then flags failure.
module oprom_top
  import oprom_pkg::*;
#(
  parameter int ROM_SIZE = ROM_BYTES
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] modeSelect,
  input wire logic largePackage,
  input wire logic busReq,
  input wire logic [1:0] busMaster,
  input wire logic [31:0] busAddr,
  input wire logic [1:0] busSize,
  output logic busHit,
  output logic busAck,
  output logic [31:0] busRdata,
  output logic romEnable,
  output logic singleChip,
  output logic [1:0] area0Width,
  output logic promMode,
  input wire logic chipEnable_n,
  input wire logic outputEnable_n,
  input wire logic program_strobe_n,
  input wire logic [ROM_AW-1:0] prom_address_inputs,
  input wire logic [7:0] prom_data_lines_in,
  output logic [7:0] prom_data_lines_out,
  output logic prom_data_lines_oe
);
  initial begin
    if (ROM_SIZE != ROM_BYTES) begin
      $error("only the 128 kbyte array is supported");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  oprom_mode_if modeIf ();
  oprom_mode_dec uDec (
    .mclk(mclk),
    .rst_n(rst_n),
    .modeSelect(modeSelect),
    .largePackage(largePackage),
    .modeIf(modeIf)
  );
  assign romEnable = modeIf.romEnable;
  assign singleChip = modeIf.singleChip;
  assign area0Width = modeIf.area0Width;
  assign promMode = modeIf.promMode;

  ////////////////////////////////////////////////////////////////////////
  // Array, byte lanes big-endian within a word
  logic [7:0] romMem [ROM_BYTES];

  function automatic logic inRom(input logic [31:0] a);
    return (a >= ROM_BASE) && (a <= ROM_TOP);
  endfunction

  function automatic logic [31:0] fetch(input logic [ROM_AW-1:0] a, input logic [1:0] sz);
    logic [ROM_AW-1:0] w;
    logic [31:0] r;
    w = {a[ROM_AW-1:2], 2'h0};
    r = '0;
    unique case (sz)
      SIZE_BYTE: r = {24'h00_0000, romMem[a]};
      SIZE_HALF: r = {16'h0000, romMem[{a[ROM_AW-1:1], 1'h0}], romMem[{a[ROM_AW-1:1], 1'h1}]};
      default: r = {romMem[w], romMem[w | 17'h00001], romMem[w | 17'h00002], romMem[w | 17'h00003]};
    endcase
    return r;
  endfunction

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] pdata;
    logic poe;
  } oprom_st_t;
  oprom_st_t st_ff, nxt_st;

  logic readHit;
  logic promWrite;
  logic promVerify;

  // RULE3: decode at area 0 bottom
  assign readHit = busReq && modeIf.romEnable && !modeIf.promMode && inRom(busAddr);
  assign busHit = readHit;
  // RULE11: strobe encoding
  assign promWrite = modeIf.promMode && !chipEnable_n && outputEnable_n && !program_strobe_n;
  assign promVerify = modeIf.promMode && !chipEnable_n && !outputEnable_n && program_strobe_n;

  always_comb begin
    nxt_st = st_ff;
    // RULE2: one-cycle answer
    nxt_st.ack = readHit;
    // RULE1: sized read, any master
    nxt_st.rdata = readHit ? fetch(busAddr[ROM_AW-1:0], busSize) : 32'h0000_0000;
    // RULE10: verify drives stored byte
    nxt_st.poe = promVerify;
    nxt_st.pdata = promVerify ? romMem[prom_address_inputs] : 8'h00;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // RULE12: byte write, no page buffer
  always_ff @(posedge mclk) begin
    if (rst_n && promWrite) begin
      romMem[prom_address_inputs] <= romMem[prom_address_inputs] & prom_data_lines_in;
    end
  end

  assign busAck = st_ff.ack;
  assign busRdata = st_ff.rdata;
  assign prom_data_lines_out = st_ff.pdata;
  assign prom_data_lines_oe = st_ff.poe;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_read_onecycle: assert property (@(posedge mclk) disable iff (!rst_n)
    readHit |=> busAck) // RULE2
    else $error("read not answered in one cycle");
  a_no_stray_ack: assert property (@(posedge mclk) disable iff (!rst_n)
    !readHit |=> !busAck) // RULE3
    else $error("ack without hit");
  a_byte_zero_ext: assert property (@(posedge mclk) disable iff (!rst_n)
    readHit && busSize == SIZE_BYTE |=> busRdata[31:8] == 24'h00_0000) // RULE1
    else $error("byte read not zero extended");
  a_disabled_nohit: assert property (@(posedge mclk) disable iff (!rst_n)
    !modeIf.romEnable |-> !busHit) // RULE4
    else $error("hit while disabled");
  a_verify_drive: assert property (@(posedge mclk) disable iff (!rst_n)
    promVerify |=> prom_data_lines_oe) // RULE10
    else $error("verify not driven");
  a_float_other: assert property (@(posedge mclk) disable iff (!rst_n)
    !promVerify |=> !prom_data_lines_oe) // RULE11
    else $error("data lines driven outside verify");
  a_write_float: assert property (@(posedge mclk) disable iff (!rst_n)
    promWrite |=> !prom_data_lines_oe) // RULE9
    else $error("driven during write");
  c_word_read: cover property (@(posedge mclk) readHit && busSize == SIZE_WORD);
  c_prom_write: cover property (@(posedge mclk) promWrite);
  c_write_verify: cover property (@(posedge mclk) promWrite ##[1:20] promVerify);
endmodule
`default_nettype wire

// ===== verification/oprom_prog_model.sv
// Programmer model for the byte-wide programming port
`default_nettype none
module oprom_prog_model (
  input wire logic mclk,
  output logic ceN,
  output logic oeN,
  output logic pgmN,
  output logic [16:0] addr,
  output logic [7:0] dq,
  input wire logic [7:0] rdq,
  input wire logic rdqOe
);
  timeunit 1ns;
  timeprecision 1ps;
  int badRun = 0;
  logic abortRun = 1'h0;
  initial begin
    {ceN, oeN, pgmN} = 3'h7;
    addr = 17'h0;
    dq = 8'h0;
  end
  ////////////////////////////////////////////////////////////////
  // one byte per write code
  task automatic pulse(input logic [16:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    dq = d;
    {ceN, oeN, pgmN} = 3'h2;
    @(negedge mclk);
    dq = ~d;
    {ceN, oeN, pgmN} = 3'h7;
  endtask
  task automatic drive(input logic [2:0] c, input logic [16:0] a, output logic [7:0] r, output logic o);
    @(negedge mclk);
    addr = a;
    {ceN, oeN, pgmN} = c;
    @(negedge mclk);
    r = rdq;
    o = rdqOe;
    {ceN, oeN, pgmN} = 3'h7;
  endtask
  task automatic prog_byte(input logic [16:0] a, input logic [7:0] d, output logic [7:0] r, output logic o);
    for (int i = 0; i < 3; i++) begin
      pulse(a, d);
      drive(3'h1, a, r, o);
      if (o === 1'h1 && (r | d) === d) break;
    end
    badRun = (o === 1'h1 && (r | d) === d) ? 0 : badRun + 1;
    abortRun = badRun > 1;
  endtask
endmodule
`default_nettype wire

// ===== verification/oprom_top_tb.sv
// Testbench: mode decode, internal reads, programming port
`default_nettype none
module oprom_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import oprom_pkg::*;
  logic mclk = 1'h0, rst_n = 1'h0, largePackage = 1'h0, busReq = 1'h0;
  logic [3:0] modeSelect = 4'hf;
  logic [1:0] busMaster = 2'h0, busSize = 2'h0, area0Width;
  logic [31:0] busAddr = 32'h0, busRdata;
  logic busHit, busAck, romEnable, singleChip, promMode, ceN, oeN, pgmN, dOe;
  logic [16:0] pAddr, base;
  logic [7:0] dq, dOut;
  logic [7:0] mem [logic [16:0]];
  int fails = 0, cmp_count = 0;
  initial forever #12.5 mclk = ~mclk;
  oprom_prog_model pm (.mclk, .ceN, .oeN, .pgmN, .addr(pAddr), .dq, .rdq(dOut), .rdqOe(dOe));
  oprom_top uut (.mclk, .rst_n, .modeSelect, .largePackage, .busReq, .busMaster, .busAddr, .busSize,
    .busHit, .busAck, .busRdata, .romEnable, .singleChip, .area0Width, .promMode,
    .chipEnable_n(ceN), .outputEnable_n(oeN), .program_strobe_n(pgmN), .prom_address_inputs(pAddr),
    .prom_data_lines_in(dq), .prom_data_lines_out(dOut), .prom_data_lines_oe(dOe));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // Unwritten cell bits stay unknown, so only cleared bits count
  task automatic chk_rom(input logic [31:0] got, input logic [31:0] exp, input string m);
    chk(got | exp, exp, m);
  endtask
  function automatic logic [31:0] exp_rd(input logic [16:0] a, input logic [1:0] s);
    logic [16:0] w;
    w = {a[16:2], 2'h0};
    if (s == SIZE_BYTE) return {24'h0, mem[a]};
    if (s == SIZE_HALF) return {16'h0, mem[{a[16:1], 1'h0}], mem[{a[16:1], 1'h1}]};
    return {mem[w], mem[w | 17'h1], mem[w | 17'h2], mem[w | 17'h3]};
  endfunction
  task automatic rd(input logic [31:0] a, input logic [1:0] s, input logic hit);
    @(negedge mclk);
    busAddr = a;
    busSize = s;
    busMaster = 2'($urandom_range(2));
    busReq = 1'h1;
    #1 chk(busHit, hit, "hit");
    @(negedge mclk);
    busReq = 1'h0;
    chk(busAck, hit, "ack");
    if (hit) chk_rom(busRdata, exp_rd(a[16:0], s), "rdata");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d, r;
    logic o;
    void'($urandom(53));
    repeat (10) @(negedge mclk);
    rst_n = 1'h1;
    repeat (2) @(negedge mclk);
    chk(promMode, 1, "prom");
    rd(ROM_BASE, SIZE_WORD, 1'h0);
    base = 17'($urandom) & 17'h1fffc;
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      mem[17'(base + i)] = d;
      pm.prog_byte(17'(base + i), d, r, o);
      chk(o, 1, "oe");
      chk_rom({24'h0, r}, {24'h0, d}, "verify");
    end
    for (int c = 0; c < 8; c++) if (c != 2) begin
      pm.drive(3'(c), base, r, o);
      chk(o, c == 1, "code");
    end
    $display("test prom done");
    for (int m = 0; m < 30; m++) begin
      modeSelect = 4'(m >> 1);
      largePackage = m[0];
      repeat (2) @(negedge mclk);
      chk(romEnable, modeSelect[1], "rom");
      chk(singleChip, &modeSelect[1:0], "single");
      chk(promMode, 0, "prom");
      if (!modeSelect[1]) chk(area0Width, {1'h0, modeSelect[0]} + {1'h0, largePackage}, "width");
      else if (!modeSelect[0]) chk(area0Width, BUS_WBSC, "width");
      rd({15'h0, base} + 32'($urandom_range(3)), 2'($urandom_range(2)), modeSelect[1]);
      rd(ROM_TOP + 32'h1, SIZE_BYTE, 1'h0);
    end
    $display("test modes done");
    close_out();
  end
  // Whole run is a few hundred cycles; allow far more
  initial begin
    #50000;
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
